// ### verilog/dtp_consts.svh
`ifndef DTP_CONSTS_SVH
`define DTP_CONSTS_SVH

// local clock and termination windows, times in ns
`define DTP_CLK_NS        5
`define DTP_TERMINATION_ENABLE_WINDOW_MIN_NS  12
`define DTP_TERMINATION_DISABLE_WINDOW_MAX_NS  12
// enable wait rounds up, disable bound rounds down, neither below one cycle
`define DTP_ODTE_CYC ((`DTP_TERMINATION_ENABLE_WINDOW_MIN_NS + `DTP_CLK_NS - 1) / `DTP_CLK_NS)
`define DTP_ODTD_CYC (((`DTP_TERMINATION_DISABLE_WINDOW_MAX_NS / `DTP_CLK_NS) < 1) ? 1 : (`DTP_TERMINATION_DISABLE_WINDOW_MAX_NS / `DTP_CLK_NS))

// link clock period and data-path times, in ps
`define DTP_LINK_PS       1072
`define DTP_STROBE_OUTPUT_DELAY_MAX_PS 5500
`define DTP_TWR_PS        15000
`define DTP_DQSCK_CYC ((`DTP_STROBE_OUTPUT_DELAY_MAX_PS + `DTP_LINK_PS - 1) / `DTP_LINK_PS)
`define DTP_WR_CYC    ((`DTP_TWR_PS + `DTP_LINK_PS - 1) / `DTP_LINK_PS)

// link-cycle counts
`define DTP_CPDED_CYC 2
`define DTP_TXP_CYC   3
`define DTP_ENABLE_MIN_PULSE_CYC  3
`define DTP_IHCKE_CYC 1
`define DTP_TMRW_CYC  10

// default latencies
`define DTP_RL 12
`define DTP_WL 6
`define DTP_BL 8

// mode register fields
`define DTP_TERMINATION_CONFIG_REGISTER_STR_LO 0
`define DTP_TERMINATION_CONFIG_REGISTER_STR_HI 1
`define DTP_TERMINATION_CONFIG_REGISTER_PD_BIT 2
`define DTP_MR2_WL_BIT  7
`define DTP_STR_OFF     2'h0

`endif

// ### verilog/dtp_pkg.sv
package dtp_pkg;

  // command decoded from the command/address bus while chip select is low
  typedef enum logic [3:0] {
    DTP_CMD_NOP   = 4'h0,
    DTP_CMD_READ  = 4'h1,
    DTP_CMD_MRR   = 4'h2,
    DTP_CMD_WRITE = 4'h3,
    DTP_CMD_WRAP  = 4'h4,
    DTP_CMD_REF   = 4'h5,
    DTP_CMD_ACT   = 4'h6,
    DTP_CMD_PRE   = 4'h7,
    DTP_CMD_MRW   = 4'h8,
    DTP_CMD_SREF  = 4'h9,
    DTP_CMD_DSLP  = 4'ha
  } dtp_cmd_e;

  // link-side power state
  typedef enum logic [3:0] {
    DTP_ST_RUN  = 4'h1,
    DTP_ST_PD   = 4'h2,
    DTP_ST_SR   = 4'h4,
    DTP_ST_DSLP = 4'h8
  } dtp_link_state_e;

  // levels carried from the link domain to the local domain
  typedef struct packed {
    logic pd;
    logic pd_row_open;
    logic sr;
    logic dslp;
    logic rd_block;
    logic rx_off;
    logic cmd_ready;
    logic cke_early;
    logic cke_short;
  } dtp_link_stat_s;

endpackage

// ### verilog/dtp_sync.sv
`timescale 1ns/1ps
// two-flop level synchroniser; first stage feeds only the second
module dtp_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  // no reset value beyond zero: every level starts inactive
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule

// ### verilog/dtp_window_timer.sv
`timescale 1ns/1ps
// holds busy for CNT cycles after a start pulse; a new start reloads
module dtp_window_timer #(
  parameter int CNT = 3
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic start,
  output logic      busy
);
  localparam int CW = $clog2(CNT + 1);
  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;

  assign next_cnt = start ? CW'(CNT) : (cnt != '0) ? cnt - CW'(1) : cnt;
  assign busy     = (cnt != '0);

  // countdown
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end
endmodule

// ### verilog/dtp_termination_ctrl.sv
`timescale 1ns/1ps
`include "dtp_consts.svh"
// Contract
// - termination only with strength field nonzero and pin high
// - when enabled, termination follows the pin without clock sampling
// - reads and mode-register reads turn termination off, pin ignored
// - option bit clear: power-down disables, exit re-enables within windows
// - option bit set, strength nonzero: pin keeps control in power-down
// - self-refresh disables termination, exit re-enables within enable window
// - deep sleep turns termination off and keeps it off; the code lets it back on after deep-sleep exit, as for self-refresh
// - bus training keeps termination off, pin ignored
// - write leveling: only strobes terminate, and only with pin high
// - terminate during writes; never during reads, data or impedance calibration
// - read off from clock RL-2, back on from clock RL+BL/2
// - enable low with select high enters power-down; controller sends no-op next
// - two no-ops after enable low; receivers off after that delay
// - no refresh happens in power-down
// - enable high with select high exits; next command after exit latency
// - idle power-down if all banks idle, active if a row is open
// - write leveling follows bit 7 of the leveling register
module dtp_termination_ctrl #(
  parameter int RL = `DTP_RL,
  parameter int WL = `DTP_WL,
  parameter int BL = `DTP_BL
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              ck_link,
  input  wire logic              cke,
  input  wire logic              cs_n,
  input  wire dtp_pkg::dtp_cmd_e cmd,
  input  wire logic              banks_open,
  input  wire logic              termination_pin,
  input  wire logic [2:0]        termination_config_register,
  input  wire logic [7:0]        leveling_config_register,
  input  wire logic              ca_training,
  input  wire logic              zq_calibrating,
  output logic                   term_dq,
  output logic                   term_dqs,
  output logic                   powerdown,
  output logic                   powerdown_row_open,
  output logic                   self_refresh,
  output logic                   deep_sleep,
  output logic                   receivers_off,
  output logic                   refresh_allowed,
  output logic                   cmd_ready,
  output logic                   cke_early,
  output logic                   cke_short
);
  localparam int RD_OFF   = RL - 2;
  localparam int RD_ON    = RL + BL / 2;
  localparam int LOCK_RD  = RL + `DTP_DQSCK_CYC + BL / 2 + 1 - 1;
  localparam int LOCK_WR  = WL + 1 + BL / 2 + `DTP_WR_CYC - 1;
  localparam int LOCK_WRA = LOCK_WR + 1;
  localparam int ODTD_W   = `DTP_ODTD_CYC;
  localparam int ODTE_W   = `DTP_ODTE_CYC + 1;

  // ---------------- link domain (ck_link) ----------------
  dtp_pkg::dtp_link_state_e state;
  dtp_pkg::dtp_link_state_e next_state;
  dtp_pkg::dtp_link_stat_s  lstat;
  logic       cke_prev;
  logic [1:0] cpd_cnt;
  logic [1:0] next_cpd_cnt;
  logic [3:0] xp_cnt;
  logic [3:0] next_xp_cnt;
  logic [3:0] low_cnt;
  logic [7:0] rd_cnt;
  logic [7:0] next_rd_cnt;
  logic [7:0] lock_cnt;
  logic [7:0] next_lock_cnt;
  logic [7:0] lock_load;
  logic       rd_block;
  logic       rx_off;
  logic       row_open;
  logic       early;
  logic       short_low;
  logic       ready;

  // command and enable-edge decode
  wire low_edge  = cke_prev & ~cke;
  wire high_edge = ~cke_prev & cke;
  wire cmd_live  = ~cs_n & cke & cke_prev;
  wire is_read   = cmd_live & ((cmd == dtp_pkg::DTP_CMD_READ) | (cmd == dtp_pkg::DTP_CMD_MRR));
  wire in_run    = (state == dtp_pkg::DTP_ST_RUN);
  wire pd_entry  = in_run & low_edge & cs_n;
  wire sr_entry  = in_run & low_edge & ~cs_n & (cmd == dtp_pkg::DTP_CMD_SREF);
  wire ds_entry  = in_run & low_edge & ~cs_n & (cmd == dtp_pkg::DTP_CMD_DSLP);
  wire any_entry = pd_entry | sr_entry | ds_entry;
  wire lp_exit   = ~in_run & high_edge & (cs_n | (state == dtp_pkg::DTP_ST_DSLP));

  // power state sequence
  always_comb begin
    next_state = state;
    unique case (state)
      dtp_pkg::DTP_ST_RUN: begin
        if (pd_entry) begin
          next_state = dtp_pkg::DTP_ST_PD;
        end else if (sr_entry) begin
          next_state = dtp_pkg::DTP_ST_SR;
        end else if (ds_entry) begin
          next_state = dtp_pkg::DTP_ST_DSLP;
        end
      end
      dtp_pkg::DTP_ST_PD,
      dtp_pkg::DTP_ST_SR,
      dtp_pkg::DTP_ST_DSLP: begin
        if (lp_exit) begin
          next_state = dtp_pkg::DTP_ST_RUN;
        end
      end
      default: next_state = dtp_pkg::DTP_ST_RUN;
    endcase
  end

  // earliest legal enable-low point after each command type
  assign lock_load =
    !cmd_live ? 8'h00 :
    ((cmd == dtp_pkg::DTP_CMD_READ) | (cmd == dtp_pkg::DTP_CMD_MRR)) ? 8'(LOCK_RD) :
    (cmd == dtp_pkg::DTP_CMD_WRITE) ? 8'(LOCK_WR) :
    (cmd == dtp_pkg::DTP_CMD_WRAP)  ? 8'(LOCK_WRA) :
    (cmd == dtp_pkg::DTP_CMD_MRW)   ? 8'(`DTP_TMRW_CYC - 1) :
    ((cmd == dtp_pkg::DTP_CMD_REF) | (cmd == dtp_pkg::DTP_CMD_ACT) |
     (cmd == dtp_pkg::DTP_CMD_PRE)) ? 8'(`DTP_IHCKE_CYC - 1) : 8'h00;

  // the longest pending lock wins so overlapping bursts are covered
  always_comb begin
    next_lock_cnt = (lock_cnt != 8'h00) ? lock_cnt - 8'h01 : 8'h00;
    if (lock_load > next_lock_cnt) begin
      next_lock_cnt = lock_load;
    end
  end

  // read blanking counts link cycles from the last read; saturates when done
  assign next_rd_cnt  = is_read ? 8'h00 : (rd_cnt < 8'(RD_ON)) ? rd_cnt + 8'h01 : rd_cnt;
  assign next_cpd_cnt = any_entry ? 2'(`DTP_CPDED_CYC) : (cpd_cnt != 2'h0) ? cpd_cnt - 2'h1 : cpd_cnt;
  assign next_xp_cnt  = lp_exit ? 4'(`DTP_TXP_CYC) : (xp_cnt != 4'h0) ? xp_cnt - 4'h1 : xp_cnt;

  // state, counters and registered read-blank, receiver-off and ready levels
  always_ff @(posedge ck_link or negedge rst_n) begin
    if (!rst_n) begin
      state     <= dtp_pkg::DTP_ST_RUN;
      cke_prev  <= 1'b0;
      cpd_cnt   <= 2'h0;
      xp_cnt    <= 4'h0;
      rd_cnt    <= 8'(RD_ON);
      lock_cnt  <= 8'h00;
      rd_block  <= 1'b0;
      rx_off    <= 1'b0;
      ready     <= 1'b0;
    end else begin
      state     <= next_state;
      cke_prev  <= cke;
      cpd_cnt   <= next_cpd_cnt;
      xp_cnt    <= next_xp_cnt;
      rd_cnt    <= next_rd_cnt;
      lock_cnt  <= next_lock_cnt;
      rd_block  <= (next_rd_cnt >= 8'(RD_OFF)) && (next_rd_cnt < 8'(RD_ON));
      rx_off    <= (next_state != dtp_pkg::DTP_ST_RUN) && (next_cpd_cnt == 2'h0);
      // registered so the exit edge, which moves state and xp count together, cannot glitch it
      ready     <= (next_state == dtp_pkg::DTP_ST_RUN) && (next_xp_cnt == 4'h0);
    end
  end

  // row state is caught at entry to tell idle from active power-down
  always_ff @(posedge ck_link or negedge rst_n) begin
    if (!rst_n) begin
      row_open  <= 1'b0;
      low_cnt   <= 4'h0;
      early     <= 1'b0;
      short_low <= 1'b0;
    end else begin
      if (pd_entry) begin
        row_open <= banks_open;
      end
      low_cnt   <= any_entry ? 4'h1 : (!in_run && low_cnt != 4'hf) ? low_cnt + 4'h1 : low_cnt;
      early     <= early | (any_entry && lock_cnt != 8'h00);
      short_low <= short_low | (lp_exit && low_cnt < 4'(`DTP_ENABLE_MIN_PULSE_CYC));
    end
  end

  assign lstat.pd          = (state == dtp_pkg::DTP_ST_PD);
  assign lstat.pd_row_open = row_open;
  assign lstat.sr          = (state == dtp_pkg::DTP_ST_SR);
  assign lstat.dslp        = (state == dtp_pkg::DTP_ST_DSLP);
  assign lstat.rd_block    = rd_block;
  assign lstat.rx_off      = rx_off;
  assign lstat.cmd_ready   = ready;
  assign lstat.cke_early   = early;
  assign lstat.cke_short   = short_low;

  // ---------------- local domain (clk) ----------------
  // every field is a flop or a one-hot state decode, so each crosses as a clean level
  dtp_pkg::dtp_link_stat_s sstat;
  logic [$bits(dtp_pkg::dtp_link_stat_s)-1:0] sstat_bits;

  dtp_sync #(
    .W ($bits(dtp_pkg::dtp_link_stat_s))
  ) u_stat_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (lstat),
    .q     (sstat_bits)
  );
  assign sstat = dtp_pkg::dtp_link_stat_s'(sstat_bits);

  // configuration decode
  wire cfg_on  = termination_config_register[`DTP_TERMINATION_CONFIG_REGISTER_STR_HI:`DTP_TERMINATION_CONFIG_REGISTER_STR_LO] != `DTP_STR_OFF;
  wire pd_opt  = termination_config_register[`DTP_TERMINATION_CONFIG_REGISTER_PD_BIT];
  wire wl_mode = leveling_config_register[`DTP_MR2_WL_BIT];

  // low-power states that take the pin away; option bit keeps it in power-down
  wire blk_state = (sstat.pd & ~pd_opt) | sstat.sr | sstat.dslp;
  logic blk_q;
  logic enable_wait;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      blk_q <= 1'b0;
    end else begin
      blk_q <= blk_state;
    end
  end

  // re-enable waits out the minimum enable window after any exit
  dtp_window_timer #(
    .CNT (`DTP_ODTE_CYC)
  ) u_enable_wait (
    .clk   (clk),
    .rst_n (rst_n),
    .start (blk_q & ~blk_state),
    .busy  (enable_wait)
  );

  // blk_q bridges the cycle between the synced exit and the timer load,
  // otherwise termination would flicker on before the enable window starts
  wire hold = blk_state | blk_q | enable_wait;

  // the pin reaches the switches through gates only, no flop in its path,
  // so turn-on and turn-off follow it as fast as the analog path allows
  wire term_on = termination_pin & cfg_on & ~hold & ~sstat.rd_block
               & ~ca_training & ~zq_calibrating;
  assign term_dqs = term_on;
  assign term_dq  = term_on & ~wl_mode;

  // status outputs from flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      refresh_allowed <= 1'b0;
    end else begin
      refresh_allowed <= ~sstat.pd & ~sstat.sr & ~sstat.dslp;
    end
  end

  assign powerdown          = sstat.pd;
  assign powerdown_row_open = sstat.pd_row_open;
  assign self_refresh       = sstat.sr;
  assign deep_sleep         = sstat.dslp;
  assign receivers_off      = sstat.rx_off;
  assign cmd_ready          = sstat.cmd_ready;
  assign cke_early          = sstat.cke_early;
  assign cke_short          = sstat.cke_short;

  // ---------------- checks ----------------
  a_strength_off_gate: assert property (@(posedge clk) disable iff (!rst_n)
    !cfg_on |-> !term_dq && !term_dqs)
    else $error("termination on with strength field zero");

  a_pin_low_gate: assert property (@(posedge clk) disable iff (!rst_n)
    !termination_pin |-> !term_dqs)
    else $error("termination on with pin low");

  a_read_blank: assert property (@(posedge clk) disable iff (!rst_n)
    sstat.rd_block |-> !term_dq && !term_dqs)
    else $error("termination on during read");

  a_pd_disable_win: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(sstat.pd) && !pd_opt |-> ##[0:ODTD_W] !term_dqs)
    else $error("power-down did not disable termination in time");

  a_pd_keep_pin: assert property (@(posedge clk) disable iff (!rst_n)
    sstat.pd && pd_opt && !blk_q && !enable_wait && termination_pin && cfg_on && !sstat.rd_block
    && !ca_training && !zq_calibrating |-> term_dqs)
    else $error("pin lost control in power-down with option set");

  a_exit_enable_win: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(blk_state) |-> hold ##[1:ODTE_W] !hold)
    else $error("termination not re-enabled within enable window");

  a_deep_sleep_off: assert property (@(posedge clk) disable iff (!rst_n)
    sstat.dslp |-> !term_dq && !term_dqs)
    else $error("termination on in deep sleep");

  a_ca_train_off: assert property (@(posedge clk) disable iff (!rst_n)
    ca_training |-> !term_dq && !term_dqs)
    else $error("termination on during bus training");

  a_level_dq_off: assert property (@(posedge clk) disable iff (!rst_n)
    wl_mode |-> !term_dq && (!term_dqs || termination_pin))
    else $error("data lines terminated in write leveling");

  a_zq_cal_off: assert property (@(posedge clk) disable iff (!rst_n)
    zq_calibrating |-> !term_dqs)
    else $error("termination on during impedance calibration");

  a_read_window: assert property (@(posedge ck_link) disable iff (!rst_n)
    is_read ##1 !is_read [*2] |-> !rd_block || (RD_OFF <= 2))
    else $error("read blanking started before RL-2");

  a_pd_entry_seq: assert property (@(posedge ck_link) disable iff (!rst_n)
    pd_entry |=> state == dtp_pkg::DTP_ST_PD)
    else $error("power-down not entered");

  a_rx_off_early: assert property (@(posedge ck_link) disable iff (!rst_n)
    pd_entry ##1 !cke |-> !rx_off)
    else $error("receivers off before internal delay");

  a_rx_off_late: assert property (@(posedge ck_link) disable iff (!rst_n)
    pd_entry ##1 !cke ##1 !cke |=> rx_off)
    else $error("receivers not off after internal delay");

  a_no_refresh_pd: assert property (@(posedge clk) disable iff (!rst_n)
    sstat.pd ##1 sstat.pd |-> !refresh_allowed)
    else $error("refresh allowed in power-down");

  a_exit_latency: assert property (@(posedge ck_link) disable iff (!rst_n)
    lp_exit |=> !lstat.cmd_ready ##1 !lstat.cmd_ready)
    else $error("command accepted inside exit latency");

  a_pd_kind: assert property (@(posedge ck_link) disable iff (!rst_n)
    pd_entry |=> row_open == $past(banks_open))
    else $error("power-down kind not captured");

  c_pd_round_trip: cover property (@(posedge ck_link) disable iff (!rst_n)
    pd_entry ##[1:20] lp_exit);
  c_read_blank: cover property (@(posedge clk) disable iff (!rst_n)
    termination_pin && cfg_on && sstat.rd_block);
  c_level_strobe: cover property (@(posedge clk) disable iff (!rst_n)
    wl_mode && term_dqs);
  c_sr_reenable: cover property (@(posedge clk) disable iff (!rst_n)
    $fell(sstat.sr) ##[1:ODTE_W] term_dqs);
endmodule

// ### tb/dtp_ctrl_model.sv
`timescale 1ns/1ps
// memory controller model: makes the link clock and drives the command pins
module dtp_ctrl_model (
  output logic              ck_link,
  output logic              cke,
  output logic              cs_n,
  output dtp_pkg::dtp_cmd_e cmd
);
  // free-running link clock, offset so its phase has no tie to the local clock
  initial begin
    ck_link = 1'b0;
    cke = 1'b1;
    cs_n = 1'b1;
    cmd = dtp_pkg::DTP_CMD_NOP;
    #7;
    forever #24 ck_link = ~ck_link;
  end
  // deselect cycles; command lines wander because they are don't care
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge ck_link);
      cs_n <= 1'b1;
      cmd  <= dtp_pkg::dtp_cmd_e'(4'($urandom_range(10)));
    end
  endtask
  // one command, then deselect from the edge that takes it
  task automatic issue(input dtp_pkg::dtp_cmd_e c);
    @(posedge ck_link);
    cs_n <= 1'b0;
    cmd  <= c;
    @(posedge ck_link);
    cs_n <= 1'b1;
  endtask
  // enable falls with the given select; no-ops follow the entry edge
  task automatic lower(input logic sel_n, input dtp_pkg::dtp_cmd_e c);
    @(posedge ck_link);
    cke  <= 1'b0;
    cs_n <= sel_n;
    cmd  <= c;
    @(posedge ck_link);
    cs_n <= 1'b1;
  endtask
  // exit with select high on a clock that has run steadily
  task automatic raise();
    @(posedge ck_link);
    cke  <= 1'b1;
    cs_n <= 1'b1;
    @(posedge ck_link);
  endtask
endmodule

// ### tb/test_dram_termination_and_powerdown.sv
`timescale 1ns/1ps
module test_dram_termination_and_powerdown;
  localparam int RL = 12;
  localparam int WL = 6;
  localparam int BL = 8;
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  logic              ck_link;
  logic              cke;
  logic              cs_n;
  dtp_pkg::dtp_cmd_e cmd;
  logic              banks_open = 1'b0;
  logic              termination_pin = 1'b0;
  logic [2:0]        cfg = 3'h0;
  logic [7:0]        lvl = 8'h00;
  logic              ca_training = 1'b0;
  logic              zq_calibrating = 1'b0;
  logic              term_dq, term_dqs, powerdown, powerdown_row_open, self_refresh;
  logic              deep_sleep, receivers_off, refresh_allowed, cmd_ready, cke_early, cke_short;
  int                bad_count = 0;
  int                num_checks = 0;
  int                cycles = 0;

  always #2.5 clk = ~clk;

  dtp_ctrl_model ctrl (.ck_link(ck_link), .cke(cke), .cs_n(cs_n), .cmd(cmd));

  dtp_termination_ctrl #(.RL(RL), .WL(WL), .BL(BL)) dut (
    .clk(clk), .rst_n(rst_n), .ck_link(ck_link), .cke(cke), .cs_n(cs_n), .cmd(cmd),
    .banks_open(banks_open), .termination_pin(termination_pin),
    .termination_config_register(cfg), .leveling_config_register(lvl),
    .ca_training(ca_training), .zq_calibrating(zq_calibrating),
    .term_dq(term_dq), .term_dqs(term_dqs), .powerdown(powerdown),
    .powerdown_row_open(powerdown_row_open), .self_refresh(self_refresh),
    .deep_sleep(deep_sleep), .receivers_off(receivers_off), .refresh_allowed(refresh_allowed),
    .cmd_ready(cmd_ready), .cke_early(cke_early), .cke_short(cke_short)
  );

  task automatic finish_test();
    if (bad_count == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %b seen %b", name, exp, got);
    end
  endtask

  // expected {strobe, data} termination; off folds in any device-state blanking
  function automatic logic [1:0] exp_term(input logic off);
    logic on;
    on = termination_pin && (cfg[1:0] != 2'h0) && !off && !ca_training && !zq_calibrating;
    return {on, on && !lvl[7]};
  endfunction

  task automatic chk_term(input logic off);
    logic [1:0] e;
    e = exp_term(off);
    check("term_dqs", e[1], term_dqs);
    check("term_dq", e[0], term_dq);
  endtask

  // hang guard, far above the under two thousand cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      finish_test();
    end
  end

  initial begin
    logic       w;
    logic       bo;
    logic [2:0] c;
    void'($urandom(32'heda60102));
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    ctrl.idle(4);
    #20;
    check("cmd_ready", 1'b1, cmd_ready);
    check("refresh_allowed", 1'b1, refresh_allowed);
    // random pin and mode mix; checked 1 ns after the edge, before any clocked path
    for (int i = 0; i < 40; i++) begin
      w = ($urandom_range(3) == 0);
      c = 3'($urandom);
      @(posedge clk);
      cfg <= c;
      lvl <= {w, 7'($urandom)};
      ca_training <= ($urandom_range(7) == 0);
      zq_calibrating <= ($urandom_range(7) == 0);
      termination_pin <= (w && c[1:0] != 2'h0) ? 1'b1 : 1'($urandom);
      #1;
      chk_term(1'b0);
    end
    @(posedge clk);
    cfg <= 3'h1;
    lvl <= 8'h00;
    ca_training <= 1'b0;
    zq_calibrating <= 1'b0;
    termination_pin <= 1'b1;
    // read, register read and write: blanking only for the two reads
    for (int i = 0; i < 3; i++) begin
      ctrl.issue(i == 0 ? dtp_pkg::DTP_CMD_READ : i == 1 ? dtp_pkg::DTP_CMD_MRR : dtp_pkg::DTP_CMD_WRITE);
      for (int k = 1; k <= 18; k++) begin
        @(posedge ck_link);
        #20;
        if (k != RL + BL / 2) chk_term(i < 2 && k >= RL - 2 && k < RL + BL / 2);
      end
      ctrl.idle(8);
    end
    // power-down without and with pin control, self-refresh, deep sleep
    for (int i = 0; i < 4; i++) begin
      bo = 1'($urandom);
      @(posedge clk);
      cfg <= {(i == 1), 2'h2};
      banks_open <= bo;
      ctrl.idle(3);
      ctrl.lower(i < 2, i == 2 ? dtp_pkg::DTP_CMD_SREF : dtp_pkg::DTP_CMD_DSLP);
      @(posedge ck_link);
      #20;
      check("receivers_off", 1'b0, receivers_off);
      chk_term(i != 1);
      repeat (3) @(posedge ck_link);
      #20;
      check("powerdown", i < 2, powerdown);
      if (i < 2) check("row_open", bo, powerdown_row_open);
      if (i < 2) check("receivers_off", 1'b1, receivers_off);
      check("self_refresh", i == 2, self_refresh);
      check("deep_sleep", i == 3, deep_sleep);
      check("refresh_allowed", 1'b0, refresh_allowed);
      check("cmd_ready", 1'b0, cmd_ready);
      chk_term(i != 1);
      ctrl.raise();
      #20;
      if (i < 3) check("cmd_ready", 1'b0, cmd_ready);
      if (i < 3) chk_term(i != 1);
      repeat (4) @(posedge ck_link);
      #20;
      check("powerdown", 1'b0, powerdown);
      if (i < 3) check("cmd_ready", 1'b1, cmd_ready);
      if (i < 3) check("refresh_allowed", 1'b1, refresh_allowed);
      if (i < 3) chk_term(1'b0);
    end
    // activate then power-down at once: input hold of one cycle is already met
    ctrl.issue(dtp_pkg::DTP_CMD_ACT);
    ctrl.lower(1'b1, dtp_pkg::DTP_CMD_NOP);
    ctrl.idle(2);
    #20;
    check("powerdown", 1'b1, powerdown);
    ctrl.raise();
    repeat (4) @(posedge ck_link);
    #20;
    check("cmd_ready", 1'b1, cmd_ready);
    check("cke_early", 1'b0, cke_early);
    check("cke_short", 1'b0, cke_short);
    // deliberate misuse: enable drops right after a write and rises too soon
    ctrl.issue(dtp_pkg::DTP_CMD_WRAP);
    ctrl.lower(1'b1, dtp_pkg::DTP_CMD_NOP);
    ctrl.raise();
    repeat (3) @(posedge ck_link);
    #20;
    check("cke_early", 1'b1, cke_early);
    check("cke_short", 1'b1, cke_short);
    finish_test();
  end
endmodule
